// ### hdl/iod_pkg.sv
// Purpose: Shared constants and types of the instruction opcode decoder
// Assumes: 32-bit instruction words, 32-bit APB data
// Notes: Register offsets are byte addresses
`default_nettype none
package iod_pkg;
  // Register map
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_EVENT_COUNT = 8'h04;
  localparam logic [7:0] REG_LAST_FAULT = 8'h08;
  // Config fields
  localparam int CFG_DEBUG_IMPL_BIT = 0;
  localparam int CFG_EXT_IMPL_BIT = 1;
  localparam int CFG_COP2_IMPL_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
  // Primary opcode classes
  localparam logic [5:0] OPC_REG_FUNCTION = 6'h00;
  localparam logic [5:0] OPC_REG_IMMEDIATE = 6'h01;
  localparam logic [5:0] OPC_SYS_COPROC = 6'h10;
  localparam logic [5:0] OPC_FLOAT_COPROC = 6'h11;
  localparam logic [5:0] OPC_COPROC2 = 6'h12;
  localparam logic [5:0] OPC_INDEXED_FLOAT = 6'h13;
  localparam logic [5:0] OPC_MULT_EXT = 6'h1c;
  // Float formats in rs bits 23..21 of rs row 10
  localparam logic [2:0] FMT_SINGLE = 3'h0;
  localparam logic [2:0] FMT_DOUBLE = 3'h1;
  localparam logic [2:0] FMT_WORD = 3'h4;
  localparam logic [2:0] FMT_LONG = 3'h5;
  localparam logic [2:0] FMT_PAIRED = 3'h6;

  typedef enum logic [2:0] {
    CLS_PRIMARY, CLS_REGISTER_FUNCTION, CLS_REGISTER_IMMEDIATE, CLS_MULTIPLY_EXTENSION,
    CLS_SYSTEM_COPROCESSOR, CLS_FLOAT_COPROCESSOR, CLS_COPROCESSOR2, CLS_INDEXED_FLOAT
  } iod_class_e;

  typedef enum logic [5:0] {
    OP_RESERVED, OP_GENERAL, OP_SYSTEM_CALL, OP_BREAKPOINT, OP_MEMORY_SYNC,
    OP_TRAP_IMMEDIATE, OP_MOVE_IF_FLAG_FALSE, OP_MOVE_IF_FLAG_TRUE,
    OP_COUNT_LEAD_ZEROS, OP_COUNT_LEAD_ONES, OP_DCOUNT_LEAD_ZEROS, OP_DCOUNT_LEAD_ONES,
    OP_SOFTWARE_DEBUG_BREAKPOINT, OP_MOVE_FROM_COPROCESSOR, OP_DWORD_MOVE_FROM_COPROCESSOR,
    OP_CONTROL_MOVE_FROM_COPROCESSOR, OP_MOVE_TO_COPROCESSOR, OP_DWORD_MOVE_TO_COPROCESSOR,
    OP_CONTROL_MOVE_TO_COPROCESSOR, OP_BRANCH_ON_FALSE, OP_BRANCH_ON_TRUE,
    OP_BRANCH_ON_FALSE_LIKELY, OP_BRANCH_ON_TRUE_LIKELY, OP_FP_BRANCH_ANY_OF_TWO,
    OP_FP_BRANCH_ANY_OF_FOUR, OP_COPROCESSOR_OPERATION, OP_TLB_READ, OP_TLB_WRITE_INDEXED,
    OP_TLB_WRITE_RANDOM, OP_TLB_PROBE, OP_EXCEPTION_RETURN, OP_DEBUG_RETURN, OP_STANDBY,
    OP_FP_ARITH, OP_FP_COMPARE, OP_FP_CONVERT_TO_SINGLE, OP_FP_CONVERT_TO_DOUBLE,
    OP_CONVERT_TO_PAIRED_SINGLE, OP_FP_CONVERT_UPPER_TO_SINGLE, OP_FP_CONVERT_LOWER_TO_SINGLE,
    OP_PAIR_COMBINE_LOWER_LOWER, OP_PAIR_COMBINE_LOWER_UPPER, OP_PAIR_COMBINE_UPPER_LOWER,
    OP_PAIR_COMBINE_UPPER_UPPER, OP_FUSED_MULTIPLY_ADD, OP_FUSED_MULTIPLY_SUB,
    OP_NEG_FUSED_MULTIPLY_ADD, OP_NEG_FUSED_MULTIPLY_SUB, OP_INDEXED_PREFETCH
  } iod_op_e;
endpackage
`default_nettype wire

// ### hdl/iod_decoder.sv
// Purpose: Combinational decode of a 32-bit instruction word with exception flags
// Assumes: Mode inputs come from core logic on clk; APB slave for configuration
// Notes: Decode outputs follow the instruction word in the same cycle
// How it works
// - Unimplemented debug encodings raise reserved-instruction.
// - Debug encodings match only their exact listed field code.
// - Extension codes raise reserved-instruction when the extension is absent.
// - Primary opcode picks the class by row and column.
// - Register-function class decodes function row and column.
// - Register-immediate rt row 01 traps; row 11 all reserved.
// - Multiply-extension: count leading zeros/ones, 64-bit forms, debug breakpoint.
// - Bit 16 selects move-if-flag-false or move-if-flag-true.
// - Branch rt bit 16 picks true or false, bit 17 likely.
// - System coprocessor allows only four register moves in rs row 00; row 01 is reserved.
// - System coprocessor operations decoded by function; others reserved.
// - Float coprocessor rs row 10 formats, row 01 branch classes.
// - Single format: row 000 arithmetic, rows 110-111 compares.
// - Double format matches single except conversions in row 100.
// - Word and long formats only convert; long needs 64-bit enable.
// - Paired format needs 64-bit enable; pair combines and upper convert.
// - Indexed float class needs 64-bit enable; fused ops and prefetch.
// - Undefined behaviour only reachable from privileged or coprocessor-0 usable code.
// - Reserved cells raise reserved-instruction.
// - 64-bit-only encodings need kernel, debug or 64-bit enable.
// - Unassigned partner cells raise reserved or coprocessor-unusable.
//
// Design decisions made here: the register addresses and the APB slave port.
`default_nettype none
module iod_decoder #(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction and mode state
  input wire logic [31:0] instrWord,
  input wire logic instrValid,
  input wire logic kernelMode,
  input wire logic debugMode,
  input wire logic enable64,
  input wire logic [3:0] copUsable,
  // Decode results
  output iod_pkg::iod_class_e instrClass,
  output iod_pkg::iod_op_e opId,
  output logic reservedInstr,
  output logic copUnusable,
  output logic [1:0] copUnusableNum
);

  // Generic coprocessor move decode of rs bits 23..21
  function automatic iod_pkg::iod_op_e coprocMove(input logic [2:0] col);
    case (col)
      3'h0: coprocMove = iod_pkg::OP_MOVE_FROM_COPROCESSOR;
      3'h1: coprocMove = iod_pkg::OP_DWORD_MOVE_FROM_COPROCESSOR;
      3'h2: coprocMove = iod_pkg::OP_CONTROL_MOVE_FROM_COPROCESSOR;
      3'h4: coprocMove = iod_pkg::OP_MOVE_TO_COPROCESSOR;
      3'h5: coprocMove = iod_pkg::OP_DWORD_MOVE_TO_COPROCESSOR;
      3'h6: coprocMove = iod_pkg::OP_CONTROL_MOVE_TO_COPROCESSOR;
      default: coprocMove = iod_pkg::OP_RESERVED;
    endcase
  endfunction

  // Coprocessor branch decode of rt bits 17..16
  function automatic iod_pkg::iod_op_e branchOp(input logic [1:0] cond);
    case (cond)
      2'h0: branchOp = iod_pkg::OP_BRANCH_ON_FALSE;
      2'h1: branchOp = iod_pkg::OP_BRANCH_ON_TRUE;
      2'h2: branchOp = iod_pkg::OP_BRANCH_ON_FALSE_LIKELY;
      default: branchOp = iod_pkg::OP_BRANCH_ON_TRUE_LIKELY;
    endcase
  endfunction

  logic [5:0] opc;
  logic [5:0] fn;
  logic [4:0] rs;
  logic [2:0] fnRow;
  logic [2:0] fnCol;
  logic [2:0] cfg_q;
  logic [CNT_W-1:0] rsvCount_q;
  logic [CNT_W-1:0] unusCount_q;
  logic [31:0] lastFault_q;
  logic [31:0] prdata_q;
  logic err_q;
  iod_pkg::iod_class_e cls;
  iod_pkg::iod_op_e op;
  iod_pkg::iod_op_e fpOp;
  logic rsv, need64, needExt, needDbg, copNeed;
  logic fpRsv, fpNeed64, fpNeedExt;
  logic [1:0] copNum;
  logic copAccess, allow64, dbgImpl, extImpl, cop2Impl;
  logic apbSetup, apbWrite, addrOk;
  logic rsvHit, unusHit, countClear;

  assign opc = instrWord[31:26];
  assign rs = instrWord[25:21];
  assign fn = instrWord[5:0];
  assign fnRow = fn[5:3];
  assign fnCol = fn[2:0];
  assign dbgImpl = cfg_q[iod_pkg::CFG_DEBUG_IMPL_BIT];
  assign extImpl = cfg_q[iod_pkg::CFG_EXT_IMPL_BIT];
  assign cop2Impl = cfg_q[iod_pkg::CFG_COP2_IMPL_BIT];

  // Float function decode for the format in rs bits 23..21
  always_comb
  begin
    fpOp = iod_pkg::OP_GENERAL;
    fpRsv = 1'b0;
    fpNeed64 = 1'b0;
    fpNeedExt = 1'b0;
    if (rs[2:0] == iod_pkg::FMT_SINGLE || rs[2:0] == iod_pkg::FMT_DOUBLE)
    begin
      case (fnRow)
        3'h0: fpOp = iod_pkg::OP_FP_ARITH;
        3'h1: fpNeed64 = ~fnCol[2];
        3'h2:
        begin
          case (fnCol)
            3'h1: fpOp = instrWord[16] ? iod_pkg::OP_MOVE_IF_FLAG_TRUE :
                                         iod_pkg::OP_MOVE_IF_FLAG_FALSE;
            3'h2, 3'h3: fpOp = iod_pkg::OP_GENERAL;
            3'h5, 3'h6: fpNeed64 = 1'b1;
            default: fpRsv = 1'b1;
          endcase
        end
        3'h3:
        begin
          fpRsv = ~fnCol[2];
          fpNeedExt = fnCol[2];
          fpNeed64 = fnCol[2];
        end
        3'h4:
        begin
          case (fnCol)
            3'h0:
            begin
              fpOp = iod_pkg::OP_FP_CONVERT_TO_SINGLE;
              fpRsv = rs[2:0] != iod_pkg::FMT_DOUBLE;
            end
            3'h1:
            begin
              fpOp = iod_pkg::OP_FP_CONVERT_TO_DOUBLE;
              fpRsv = rs[2:0] != iod_pkg::FMT_SINGLE;
            end
            3'h4: fpOp = iod_pkg::OP_GENERAL;
            3'h5: fpNeed64 = 1'b1;
            3'h6:
            begin
              fpOp = iod_pkg::OP_CONVERT_TO_PAIRED_SINGLE;
              fpRsv = rs[2:0] != iod_pkg::FMT_SINGLE;
              fpNeed64 = 1'b1;
            end
            default: fpRsv = 1'b1;
          endcase
        end
        3'h5: fpRsv = 1'b1;
        default: fpOp = iod_pkg::OP_FP_COMPARE;
      endcase
    end
    else if (rs[2:0] == iod_pkg::FMT_WORD || rs[2:0] == iod_pkg::FMT_LONG)
    begin
      case (fn)
        6'h20: fpOp = iod_pkg::OP_FP_CONVERT_TO_SINGLE;
        6'h21: fpOp = iod_pkg::OP_FP_CONVERT_TO_DOUBLE;
        6'h26:
        begin
          fpOp = iod_pkg::OP_CONVERT_TO_PAIRED_SINGLE;
          fpNeedExt = 1'b1;
          fpNeed64 = 1'b1;
        end
        default: fpRsv = 1'b1;
      endcase
    end
    else
    begin
      case (fnRow)
        3'h0:
        begin
          fpOp = iod_pkg::OP_FP_ARITH;
          fpRsv = fnCol == 3'h3 || fnCol == 3'h4;
        end
        3'h2:
        begin
          fpOp = instrWord[16] ? iod_pkg::OP_MOVE_IF_FLAG_TRUE :
                                 iod_pkg::OP_MOVE_IF_FLAG_FALSE;
          if (fnCol != 3'h1)
            fpOp = iod_pkg::OP_GENERAL;
          fpRsv = fnCol == 3'h0 || fnCol[2];
        end
        3'h3:
        begin
          fpRsv = fnCol == 3'h1 || fnCol == 3'h3;
          fpNeedExt = 1'b1;
        end
        3'h4:
        begin
          fpOp = fnCol == 3'h0 ? iod_pkg::OP_FP_CONVERT_UPPER_TO_SINGLE : iod_pkg::OP_GENERAL;
          fpNeedExt = fnCol == 3'h4;
          fpRsv = fnCol != 3'h0 && fnCol != 3'h4;
        end
        3'h5:
        begin
          case (fnCol)
            3'h0: fpOp = iod_pkg::OP_FP_CONVERT_LOWER_TO_SINGLE;
            3'h4: fpOp = iod_pkg::OP_PAIR_COMBINE_LOWER_LOWER;
            3'h5: fpOp = iod_pkg::OP_PAIR_COMBINE_LOWER_UPPER;
            3'h6: fpOp = iod_pkg::OP_PAIR_COMBINE_UPPER_LOWER;
            3'h7: fpOp = iod_pkg::OP_PAIR_COMBINE_UPPER_UPPER;
            default: fpRsv = 1'b1;
          endcase
        end
        3'h1: fpRsv = 1'b1;
        default: fpOp = iod_pkg::OP_FP_COMPARE;
      endcase
    end
  end

  // Class and operation decode
  always_comb
  begin
    cls = iod_pkg::CLS_PRIMARY;
    op = iod_pkg::OP_GENERAL;
    rsv = 1'b0;
    need64 = 1'b0;
    needExt = 1'b0;
    needDbg = 1'b0;
    copNeed = 1'b0;
    copNum = 2'h0;
    case (opc)
      iod_pkg::OPC_REG_FUNCTION:
      begin
        cls = iod_pkg::CLS_REGISTER_FUNCTION;
        case (fn)
          6'h01: op = instrWord[16] ? iod_pkg::OP_MOVE_IF_FLAG_TRUE :
                                      iod_pkg::OP_MOVE_IF_FLAG_FALSE;
          6'h0c: op = iod_pkg::OP_SYSTEM_CALL;
          6'h0d: op = iod_pkg::OP_BREAKPOINT;
          6'h0f: op = iod_pkg::OP_MEMORY_SYNC;
          6'h05, 6'h0e, 6'h15, 6'h28, 6'h29, 6'h35, 6'h37, 6'h39, 6'h3d: rsv = 1'b1;
          6'h14, 6'h16, 6'h17, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h2c, 6'h2d, 6'h2e, 6'h2f,
          6'h38, 6'h3a, 6'h3b, 6'h3c, 6'h3e, 6'h3f: need64 = 1'b1;
          default: op = iod_pkg::OP_GENERAL;
        endcase
      end
      iod_pkg::OPC_REG_IMMEDIATE:
      begin
        cls = iod_pkg::CLS_REGISTER_IMMEDIATE;
        if (instrWord[20:19] == 2'h3)
          rsv = 1'b1;
        else if (instrWord[20:19] == 2'h1)
        begin
          op = iod_pkg::OP_TRAP_IMMEDIATE;
          rsv = instrWord[18:16] == 3'h5 || instrWord[18:16] == 3'h7;
        end
        else
          rsv = instrWord[18];
      end
      iod_pkg::OPC_MULT_EXT:
      begin
        cls = iod_pkg::CLS_MULTIPLY_EXTENSION;
        case (fn)
          6'h00, 6'h01, 6'h02, 6'h04, 6'h05: op = iod_pkg::OP_GENERAL;
          6'h20: op = iod_pkg::OP_COUNT_LEAD_ZEROS;
          6'h21: op = iod_pkg::OP_COUNT_LEAD_ONES;
          6'h24:
          begin
            op = iod_pkg::OP_DCOUNT_LEAD_ZEROS;
            need64 = 1'b1;
          end
          6'h25:
          begin
            op = iod_pkg::OP_DCOUNT_LEAD_ONES;
            need64 = 1'b1;
          end
          6'h3f:
          begin
            op = iod_pkg::OP_SOFTWARE_DEBUG_BREAKPOINT;
            needDbg = 1'b1;
          end
          default: rsv = 1'b1;
        endcase
      end
      iod_pkg::OPC_SYS_COPROC:
      begin
        cls = iod_pkg::CLS_SYSTEM_COPROCESSOR;
        copNeed = 1'b1;
        if (!rs[4])
        begin
          op = coprocMove(rs[2:0]);
          need64 = rs[2:0] == 3'h1 || rs[2:0] == 3'h5;
          rsv = rs[3] || rs[1];
          if (rsv)
            op = iod_pkg::OP_GENERAL;
        end
        else
        begin
          case (fn)
            6'h01: op = iod_pkg::OP_TLB_READ;
            6'h02: op = iod_pkg::OP_TLB_WRITE_INDEXED;
            6'h06: op = iod_pkg::OP_TLB_WRITE_RANDOM;
            6'h08: op = iod_pkg::OP_TLB_PROBE;
            6'h18: op = iod_pkg::OP_EXCEPTION_RETURN;
            6'h1f:
            begin
              op = iod_pkg::OP_DEBUG_RETURN;
              needDbg = 1'b1;
            end
            6'h20: op = iod_pkg::OP_STANDBY;
            default: rsv = 1'b1;
          endcase
        end
      end
      iod_pkg::OPC_FLOAT_COPROC:
      begin
        cls = iod_pkg::CLS_FLOAT_COPROCESSOR;
        copNeed = 1'b1;
        copNum = 2'h1;
        case (rs[4:3])
          2'h0:
          begin
            op = coprocMove(rs[2:0]);
            rsv = op == iod_pkg::OP_RESERVED;
            need64 = rs[2:0] == 3'h1 || rs[2:0] == 3'h5;
          end
          2'h1:
          begin
            case (rs[2:0])
              3'h0: op = branchOp(instrWord[17:16]);
              3'h1: op = iod_pkg::OP_FP_BRANCH_ANY_OF_TWO;
              3'h2: op = iod_pkg::OP_FP_BRANCH_ANY_OF_FOUR;
              default: rsv = 1'b1;
            endcase
            needExt = rs[2:0] == 3'h1 || rs[2:0] == 3'h2;
            need64 = needExt;
          end
          2'h2:
          begin
            op = fpOp;
            needExt = fpNeedExt;
            need64 = fpNeed64 || rs[2:0] == iod_pkg::FMT_LONG ||
                     rs[2:0] == iod_pkg::FMT_PAIRED;
            rsv = fpRsv || !(rs[2:0] inside {iod_pkg::FMT_SINGLE, iod_pkg::FMT_DOUBLE,
              iod_pkg::FMT_WORD, iod_pkg::FMT_LONG, iod_pkg::FMT_PAIRED});
          end
          default: rsv = 1'b1;
        endcase
      end
      iod_pkg::OPC_COPROC2:
      begin
        cls = iod_pkg::CLS_COPROCESSOR2;
        copNeed = 1'b1;
        copNum = 2'h2;
        if (!rs[4])
        begin
          if (!rs[3])
            op = coprocMove(rs[2:0]);
          else
            op = rs[2:0] == 3'h0 ? branchOp(instrWord[17:16]) : iod_pkg::OP_RESERVED;
          need64 = !rs[3] && (rs[2:0] == 3'h1 || rs[2:0] == 3'h5);
        end
        else
          op = iod_pkg::OP_COPROCESSOR_OPERATION;
        rsv = op == iod_pkg::OP_RESERVED || !cop2Impl;
      end
      iod_pkg::OPC_INDEXED_FLOAT:
      begin
        cls = iod_pkg::CLS_INDEXED_FLOAT;
        copNeed = 1'b1;
        copNum = 2'h1;
        need64 = 1'b1;
        if (fnRow[2])
        begin
          case (fnRow[1:0])
            2'h0: op = iod_pkg::OP_FUSED_MULTIPLY_ADD;
            2'h1: op = iod_pkg::OP_FUSED_MULTIPLY_SUB;
            2'h2: op = iod_pkg::OP_NEG_FUSED_MULTIPLY_ADD;
            default: op = iod_pkg::OP_NEG_FUSED_MULTIPLY_SUB;
          endcase
          rsv = !(fnCol == 3'h0 || fnCol == 3'h1 || fnCol == 3'h6);
        end
        else
        begin
          case (fn)
            6'h0f: op = iod_pkg::OP_INDEXED_PREFETCH;
            6'h00, 6'h01, 6'h05, 6'h08, 6'h09, 6'h0d, 6'h1e: op = iod_pkg::OP_GENERAL;
            default: rsv = 1'b1;
          endcase
        end
      end
      default:
      begin
        rsv = opc == 6'h1f || opc == 6'h3b;
        need64 = opc inside {6'h18, 6'h19, 6'h1a, 6'h1b, 6'h27, 6'h2c, 6'h2d,
                             6'h34, 6'h37, 6'h3c, 6'h3f};
        needExt = opc == 6'h1d || opc == 6'h1e;
        if (opc inside {6'h31, 6'h35, 6'h39, 6'h3d})
        begin
          copNeed = 1'b1;
          copNum = 2'h1;
        end
        if (opc inside {6'h32, 6'h36, 6'h3a, 6'h3e})
        begin
          copNeed = 1'b1;
          copNum = 2'h2;
          rsv = !cop2Impl;
        end
      end
    endcase
  end

  // Exception resolution; coprocessor 0 open to privileged code or when copUsable[0] is set
  assign copAccess = copNum == 2'h0 ? (copUsable[0] | kernelMode | debugMode) :
                     copUsable[copNum];
  assign allow64 = kernelMode | debugMode | enable64;
  assign copUnusable = copNeed & ~copAccess;
  assign copUnusableNum = copNum;
  assign reservedInstr = ~copUnusable & (rsv | (need64 & ~allow64) |
                         (needExt & ~extImpl) | (needDbg & ~dbgImpl));
  assign instrClass = cls;
  assign opId = (reservedInstr | copUnusable) ? iod_pkg::OP_RESERVED : op;

  // APB slave
  assign apbSetup = psel & ~penable;
  assign apbWrite = psel & penable & pwrite;
  assign addrOk = paddr == iod_pkg::REG_CONFIG || paddr == iod_pkg::REG_EVENT_COUNT ||
                  paddr == iod_pkg::REG_LAST_FAULT;
  assign pready = psel & penable;
  assign pslverr = psel & penable & err_q;
  assign prdata = prdata_q;
  assign rsvHit = instrValid & reservedInstr;
  assign unusHit = instrValid & copUnusable;
  assign countClear = apbWrite & ~err_q & paddr == iod_pkg::REG_EVENT_COUNT;

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      cfg_q <= iod_pkg::CFG_RESET;
    else if (apbWrite && !err_q && paddr == iod_pkg::REG_CONFIG && pstrb[0])
      cfg_q <= pwdata[2:0];
  end

  // Event counters; a hit in the clear cycle counts as one
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rsvCount_q <= iod_pkg::COUNT_RESET[CNT_W-1:0];
      unusCount_q <= iod_pkg::COUNT_RESET[CNT_W-1:0];
    end
    else
    begin
      if (rsvHit)
        rsvCount_q <= countClear ? {{(CNT_W-1){1'b0}}, 1'b1} : rsvCount_q + 1'b1;
      else if (countClear)
        rsvCount_q <= '0;
      if (unusHit)
        unusCount_q <= countClear ? {{(CNT_W-1){1'b0}}, 1'b1} : unusCount_q + 1'b1;
      else if (countClear)
        unusCount_q <= '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      lastFault_q <= iod_pkg::FAULT_RESET;
    else if (rsvHit || unusHit)
      lastFault_q <= instrWord;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end
    else if (apbSetup)
    begin
      err_q <= ~addrOk;
      if (pwrite || !addrOk)
        prdata_q <= 32'h0000_0000;
      else if (paddr == iod_pkg::REG_CONFIG)
        prdata_q <= {29'h0000_0000, cfg_q};
      else if (paddr == iod_pkg::REG_EVENT_COUNT)
        prdata_q <= 32'({unusCount_q, rsvCount_q});
      else
        prdata_q <= lastFault_q;
    end
  end

endmodule // iod_decoder
`default_nettype wire

// ### test/iod_decoder_assertions.sv
// Purpose: Port checks of the opcode decoder
// Assumes: Sees decoder ports only
// Notes: Bound after the module
`default_nettype none
module iod_decoder_checker #(
  parameter int CNT_W = 16
) (
  // Clock, reset, APB
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  // Instruction and modes
  input wire logic [31:0] instrWord,
  input wire logic kernelMode,
  input wire logic debugMode,
  input wire logic enable64,
  input wire logic [3:0] copUsable,
  // Decode results
  input wire iod_pkg::iod_class_e instrClass,
  input wire iod_pkg::iod_op_e opId,
  input wire logic reservedInstr,
  input wire logic copUnusable,
  input wire logic [1:0] copUnusableNum
);
  wire logic [5:0] opc = instrWord[31:26];
  wire logic user = !kernelMode && !debugMode;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_flag_forces_reserved: assert property (
    (reservedInstr || copUnusable) |-> opId == iod_pkg::OP_RESERVED) else $error("op not reserved");
  chk_register_immediate_class_row_reserved: assert property (
    opc == 6'h01 && instrWord[20:19] == 2'h3 |-> reservedInstr) else $error("rt row 3 passed");
  chk_register_immediate_class_class: assert property (
    opc == 6'h01 |-> instrClass == iod_pkg::CLS_REGISTER_IMMEDIATE) else $error("bad class");
  chk_flag_move_sense: assert property (
    opc == 6'h00 && instrWord[5:0] == 6'h01 && !reservedInstr && !copUnusable |->
    opId == (instrWord[16] ? iod_pkg::OP_MOVE_IF_FLAG_TRUE : iod_pkg::OP_MOVE_IF_FLAG_FALSE))
    else $error("move sense wrong");
  chk_indexed_gate: assert property (
    opc == 6'h13 && user && !enable64 |-> reservedInstr || copUnusable) else $error("ungated");
  chk_system_coprocessor_class_user: assert property (
    opc == 6'h10 && user && !copUsable[0] |-> copUnusable && copUnusableNum == 2'h0)
    else $error("user reached system_coprocessor_class");
  chk_lead_zeros: assert property (
    opc == 6'h1c && instrWord[5:0] == 6'h20 |-> opId == iod_pkg::OP_COUNT_LEAD_ZEROS)
    else $error("count zeros missed");
  chk_apb_ready: assert property (
    psel && !penable ##1 psel && penable |-> pready) else $error("no ready");
  cover property (copUnusable);
  cover property (reservedInstr && opc == 6'h1c);
  cover property (psel && penable);
endmodule // iod_decoder_checker
bind iod_decoder iod_decoder_checker #(.CNT_W(CNT_W)) chk_u (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pready(pready), .instrWord(instrWord),
  .kernelMode(kernelMode), .debugMode(debugMode), .enable64(enable64), .copUsable(copUsable),
  .instrClass(instrClass), .opId(opId), .reservedInstr(reservedInstr),
  .copUnusable(copUnusable), .copUnusableNum(copUnusableNum));
`default_nettype wire

// ### test/iod_fetch_model.sv
// Purpose: Fetch stage feeding the decoder
// Assumes: Word follows nextWord every cycle, whether or not issue is set
// Notes: Valid follows issue one cycle later
`default_nettype none
module iod_fetch_model (
  // Bench side
  input wire logic clk,
  input wire logic [31:0] nextWord,
  input wire logic issue,
  // Decoder side
  output logic [31:0] instrWord,
  output logic instrValid
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk)
  begin
    instrWord <= nextWord;
    instrValid <= issue;
  end
endmodule // iod_fetch_model
`default_nettype wire

// ### test/isa_opcode_decoder_bench.sv
// Purpose: Self-checking bench of the opcode decoder
// Assumes: Zero-wait APB slave
// Notes: Mode word is kernel, debug, enable64, usable
`default_nettype none
module isa_opcode_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, issue = 0, err;
  logic kernelMode = 0, debugMode = 0, enable64 = 0, instrValid, pready, pslverr;
  logic reservedInstr, copUnusable;
  logic [1:0] copUnusableNum;
  logic [3:0] copUsable = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, nextWord = 0, instrWord, prdata, q;
  iod_pkg::iod_class_e instrClass;
  iod_pkg::iod_op_e opId;
  int failures = 0, samples_checked = 0;
  always #2 clk = ~clk;
  iod_fetch_model fetch_u (.clk(clk), .nextWord(nextWord), .issue(issue),
    .instrWord(instrWord), .instrValid(instrValid));
  iod_decoder dut_u (.clk(clk), .rst_b(rst_b), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instrWord(instrWord), .instrValid(instrValid),
    .kernelMode(kernelMode), .debugMode(debugMode), .enable64(enable64),
    .copUsable(copUsable), .instrClass(instrClass), .opId(opId),
    .reservedInstr(reservedInstr), .copUnusable(copUnusable), .copUnusableNum(copUnusableNum));
  task automatic report_and_stop();
    $display("checked %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      failures++;
      report_and_stop();
    end
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic dec(input logic [31:0] w, input logic [6:0] m, input iod_pkg::iod_op_e op,
    input logic [1:0] f);
    @(posedge clk);
    nextWord <= w;
    {kernelMode, debugMode, enable64, copUsable} <= m;
    @(posedge clk);
    @(negedge clk);
    check({26'h0, opId}, {26'h0, op}, "op");
    check({30'h0, reservedInstr, copUnusable}, {30'h0, f}, "flags");
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1;
    apb(0, iod_pkg::REG_CONFIG, 0);
    check(q, 0, "config");
    apb(0, 8'h0C, 0);
    check({q[30:0], err}, 32'h0000_0001, "unmapped");
    $display("test registers done");
    dec(32'h0000_000C, 7'h00, iod_pkg::OP_SYSTEM_CALL, 2'h0);
    dec(32'h0408_0000, 7'h00, iod_pkg::OP_TRAP_IMMEDIATE, 2'h0);
    dec(32'h0418_0000, 7'h00, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h0001_0001, 7'h02, iod_pkg::OP_MOVE_IF_FLAG_TRUE, 2'h0);
    dec(32'h0000_0001, 7'h02, iod_pkg::OP_MOVE_IF_FLAG_FALSE, 2'h0);
    dec(32'h7000_0021, 7'h00, iod_pkg::OP_COUNT_LEAD_ONES, 2'h0);
    dec(32'h7000_0020, 7'h00, iod_pkg::OP_COUNT_LEAD_ZEROS, 2'h0);
    dec(32'h7000_0025, 7'h00, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h7000_0025, 7'h10, iod_pkg::OP_DCOUNT_LEAD_ONES, 2'h0);
    dec(32'h7000_003F, 7'h00, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h7400_0000, 7'h00, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h4200_0018, 7'h40, iod_pkg::OP_EXCEPTION_RETURN, 2'h0);
    dec(32'h4200_0018, 7'h00, iod_pkg::OP_RESERVED, 2'h1);
    dec(32'h4040_0000, 7'h40, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h4503_0000, 7'h02, iod_pkg::OP_BRANCH_ON_TRUE_LIKELY, 2'h0);
    dec(32'h46C0_0000, 7'h02, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h46C0_002C, 7'h12, iod_pkg::OP_PAIR_COMBINE_LOWER_LOWER, 2'h0);
    dec(32'h4620_0020, 7'h02, iod_pkg::OP_FP_CONVERT_TO_SINGLE, 2'h0);
    dec(32'h4600_0000, 7'h02, iod_pkg::OP_FP_ARITH, 2'h0);
    dec(32'h4640_0000, 7'h02, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h4680_0000, 7'h02, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h4C00_0020, 7'h02, iod_pkg::OP_RESERVED, 2'h2);
    dec(32'h4C00_0020, 7'h12, iod_pkg::OP_FUSED_MULTIPLY_ADD, 2'h0);
    apb(1, iod_pkg::REG_CONFIG, 32'h0000_0001);
    dec(32'h7000_003F, 7'h00, iod_pkg::OP_SOFTWARE_DEBUG_BREAKPOINT, 2'h0);
    dec(32'h7000_003E, 7'h00, iod_pkg::OP_RESERVED, 2'h2);
    apb(1, iod_pkg::REG_CONFIG, 32'h0000_0005);
    apb(0, iod_pkg::REG_CONFIG, 0);
    check(q, 32'h0000_0005, "config");
    dec(32'h4800_0000, 7'h04, iod_pkg::OP_MOVE_FROM_COPROCESSOR, 2'h0);
    dec(32'h4A00_0000, 7'h04, iod_pkg::OP_COPROCESSOR_OPERATION, 2'h0);
    $display("test decode done");
    @(posedge clk);
    nextWord <= 32'h0418_0000;
    issue <= 1;
    @(posedge clk);
    issue <= 0;
    apb(0, iod_pkg::REG_EVENT_COUNT, 0);
    check(q, 32'h0000_0001, "count");
    apb(0, iod_pkg::REG_LAST_FAULT, 0);
    check(q, 32'h0418_0000, "fault");
    apb(1, iod_pkg::REG_EVENT_COUNT, 0);
    apb(0, iod_pkg::REG_EVENT_COUNT, 0);
    check(q, 0, "cleared");
    $display("test counters done");
    report_and_stop();
  end
endmodule // isa_opcode_decoder_bench
`default_nettype wire
